// >>> rtl/dma_count_index_irq.sv
`timescale 1ns/1ps
`default_nettype none
module dma_count_index_irq
    import dma_count_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst_n,
    input wire globals_t globals,
    input wire logic loadValid,
    output logic loadReady,
    input wire load_t loadData,
    input wire logic stepValid,
    output logic stepReady,
    input wire chan_t stepChannel,
    output logic xferValid,
    output xfer_t xfer,
    output logic [`DMA_CHANNELS-1:0] channelActive,
    output logic [`DMA_CHANNELS-1:0] irqPulse
);
    // Picks the step that moves an address after a transfer.
    function automatic word_t pickStep(input logic sel, input logic last,
                                       input globals_t g);
        word_t e;
        word_t f;
        e = sel ? g.element_step_1 : g.element_step_0;
        f = sel ? g.frame_step_1 : g.frame_step_0;
        pickStep = last ? f : e;
    endfunction : pickStep

    logic busy;
    chan_t busyCh;
    chan_state_t cur;
    chan_state_t wrData;
    chan_state_t loadState;
    chan_state_t nextState;
    chan_t wrAddr;
    logic wrEn;

    // The channel memory has one cycle of read latency, so a step is
    // taken only when no step is in flight, and a load only when idle.
    wire logic chanOk = stepChannel < `DMA_CH_W'(`DMA_CHANNELS);
    wire logic loadFire = loadValid && loadReady;
    wire logic stepFire = stepValid && stepReady;
    wire logic stepLive = stepFire && chanOk && channelActive[stepChannel];

    assign loadReady = !busy;
    assign stepReady = !busy && !loadValid;

    dma_chan_mem u_mem (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .wrEn(wrEn),
        .wrAddr(wrAddr),
        .wrData(wrData),
        .rdAddr(stepChannel),
        .rdData(cur)
    );

    // Count decisions for the transfer now in the second stage.
    wire logic dw = cur.mode.doubleWord;
    wire logic elemDone = !dw || cur.phase;
    wire logic frameLast = elemDone &&
        (cur.element_count_reg == `DMA_ELEM_LAST);
    wire logic blockLast = frameLast &&
        (cur.frame_count_reg == `DMA_FRAME_LAST);
    wire logic autoRl = cur.mode.auto_reload_enable;
    wire logic halfPoint = elemDone && !frameLast &&
        (cur.element_count_reg == {1'b0, cur.elementInit[`DMA_WORD_W-1:1]});

    // Steps are two's complement, so the sum simply wraps.
    wire word_t srcStep = pickStep(cur.mode.source_index_select, frameLast,
                                   globals);
    wire word_t dstStep = pickStep(cur.mode.dest_index_select, frameLast,
                                   globals);
    wire word_t nextSrc = cur.source_address_reg + srcStep;
    wire word_t nextDst = cur.dest_address_reg + dstStep;

    wire word_t elemMinus = cur.element_count_reg - `DMA_ELEM_ONE;
    wire frame_t frameMinus = cur.frame_count_reg - `DMA_FRAME_ONE;

    wire word_t nextElem = blockLast ?
        (autoRl ? globals.global_count_reload : cur.element_count_reg) :
        frameLast ? cur.elementInit :
        elemDone ? elemMinus : cur.element_count_reg;
    wire word_t nextInit = (blockLast && autoRl) ?
        globals.global_count_reload : cur.elementInit;
    wire frame_t nextFrame = blockLast ?
        (autoRl ? globals.global_frame_reload : cur.frame_count_reg) :
        frameLast ? frameMinus : cur.frame_count_reg;

    // Interrupt decision: enable gates all, mode widens the events.
    wire logic modeEvent = cur.mode.auto_buffering_mode ? halfPoint
                                                        : frameLast;
    wire logic irqHit = cur.mode.irq_enable_bit &&
        (blockLast || (cur.mode.irq_mode_bit && modeEvent));

    assign nextState = '{
        phase: dw ? !cur.phase : 1'b0,
        source_address_reg: nextSrc,
        dest_address_reg: nextDst,
        element_count_reg: nextElem,
        elementInit: nextInit,
        frame_count_reg: nextFrame,
        mode: cur.mode
    };

    assign loadState = '{
        phase: 1'b0,
        source_address_reg: loadData.srcAddr,
        dest_address_reg: loadData.dstAddr,
        element_count_reg: loadData.elemCount,
        elementInit: loadData.elemCount,
        frame_count_reg: loadData.frameCount,
        mode: loadData.mode
    };

    assign wrEn = busy || loadFire;
    assign wrAddr = busy ? busyCh : loadData.channel;
    assign wrData = busy ? nextState : loadState;

    wire xfer_t next_xfer = '{
        channel: busyCh,
        srcAddr: cur.source_address_reg,
        dstAddr: cur.dest_address_reg,
        secondHalf: dw && cur.phase,
        frameEnd: frameLast,
        blockEnd: blockLast
    };

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            busy <= 1'b0;
            busyCh <= '0;
        end else begin
            busy <= stepLive;
            busyCh <= stepChannel;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            xferValid <= 1'b0;
            xfer <= '0;
        end else begin
            xferValid <= busy;
            xfer <= busy ? next_xfer : xfer;
        end
    end

    // Per-channel active and interrupt bits.
    genvar c;
    generate
        for (c = 0; c < `DMA_CHANNELS; c++) begin : g_chan
            wire logic hitHere = busy && (busyCh == `DMA_CH_W'(c));
            wire logic loadHere = loadFire &&
                (loadData.channel == `DMA_CH_W'(c));
            always_ff @(posedge core_clk or negedge rst_n) begin
                if (!rst_n) begin
                    channelActive[c] <= 1'b0;
                    irqPulse[c] <= 1'b0;
                end else begin
                    irqPulse[c] <= hitHere && irqHit;
                    if (loadHere) begin
                        channelActive[c] <= loadData.enable;
                    end else if (hitHere && blockLast && !autoRl) begin
                        channelActive[c] <= 1'b0;
                    end
                end
            end
        end
    endgenerate

    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!rst_n);

    a_step_latency: assert property (
        stepLive |=> busy ##1 xferValid
    ) else $error("accepted step did not issue a transfer");

    a_single_flight: assert property (
        xferValid |=> !xferValid
    ) else $error("transfers issued back to back");

    a_irq_gate_off: assert property (
        busy && !cur.mode.irq_enable_bit |=> irqPulse == '0
    ) else $error("interrupt raised while disabled");

    a_irq_mode_zero: assert property (
        busy && !cur.mode.irq_mode_bit && !blockLast |=> irqPulse == '0
    ) else $error("mode zero interrupt before block end");

    a_irq_block_end: assert property (
        busy && blockLast && cur.mode.irq_enable_bit
        |=> irqPulse[$past(busyCh)]
    ) else $error("no interrupt at block end");

    a_elem_count_dn: assert property (
        busy && elemDone && !frameLast
        |-> wrData.element_count_reg == cur.element_count_reg - `DMA_ELEM_ONE
    ) else $error("element count did not step down");

    a_dw_hold_count: assert property (
        busy && dw && !cur.phase
        |-> wrData.element_count_reg == cur.element_count_reg
            && wrData.phase
    ) else $error("first half of doubleword moved the count");

    a_frame_count_dn: assert property (
        busy && frameLast && !blockLast
        |-> wrData.frame_count_reg == cur.frame_count_reg - `DMA_FRAME_ONE
    ) else $error("frame count did not step down at frame end");

    a_frame_hold: assert property (
        busy && !frameLast
        |-> wrData.frame_count_reg == cur.frame_count_reg
    ) else $error("frame count moved inside a frame");

    a_auto_reload: assert property (
        busy && blockLast && autoRl
        |-> wrData.frame_count_reg == globals.global_frame_reload
            && wrData.element_count_reg == globals.global_count_reload
    ) else $error("auto reload did not load global values");

    a_block_stop: assert property (
        busy && blockLast && !autoRl
        |=> !channelActive[$past(busyCh)]
    ) else $error("channel still active after block end");

    a_frame_step: assert property (
        busy && frameLast && !cur.mode.source_index_select
        |-> wrData.source_address_reg ==
            cur.source_address_reg + globals.frame_step_0
    ) else $error("frame step not applied at frame end");

    a_elem_step: assert property (
        busy && !frameLast && cur.mode.dest_index_select
        |-> wrData.dest_address_reg ==
            cur.dest_address_reg + globals.element_step_1
    ) else $error("element step not applied");

    a_step_refused: assert property (
        busy |-> !stepReady && !loadReady
    ) else $error("request accepted while a step was in flight");

    a_src_frame_one: assert property (
        busy && frameLast && cur.mode.source_index_select
        |-> wrData.source_address_reg ==
            cur.source_address_reg + globals.frame_step_1
    ) else $error("frame step one not applied to source");

    a_dst_frame_zero: assert property (
        busy && frameLast && !cur.mode.dest_index_select
        |-> wrData.dest_address_reg ==
            cur.dest_address_reg + globals.frame_step_0
    ) else $error("frame step zero not applied to destination");

    a_src_elem_zero: assert property (
        busy && !frameLast && !cur.mode.source_index_select
        |-> wrData.source_address_reg ==
            cur.source_address_reg + globals.element_step_0
    ) else $error("element step zero not applied to source");

    a_dw_phase_wrap: assert property (
        busy && dw && cur.phase |-> !wrData.phase
    ) else $error("doubleword phase did not return to first half");

    a_single_phase: assert property (
        busy && !dw |-> !wrData.phase
    ) else $error("phase moved outside doubleword mode");

    a_frame_restart: assert property (
        busy && frameLast && !blockLast
        |-> wrData.element_count_reg == cur.elementInit
    ) else $error("element count not restarted at frame end");

    a_block_hold: assert property (
        busy && blockLast && !autoRl
        |-> wrData.frame_count_reg == cur.frame_count_reg
            && wrData.element_count_reg == cur.element_count_reg
    ) else $error("counts moved after the final block");

    a_reload_init: assert property (
        busy && blockLast && autoRl
        |-> wrData.elementInit == globals.global_count_reload
    ) else $error("frame restart value not reloaded");

    a_reload_active: assert property (
        busy && blockLast && autoRl
        |=> channelActive[$past(busyCh)]
    ) else $error("auto reload channel went inactive");

    a_irq_half_point: assert property (
        busy && halfPoint && cur.mode.auto_buffering_mode
        && cur.mode.irq_enable_bit && cur.mode.irq_mode_bit
        |=> irqPulse[$past(busyCh)]
    ) else $error("no interrupt at half buffer");

    a_irq_abu_quiet: assert property (
        busy && cur.mode.auto_buffering_mode && !blockLast && !halfPoint
        |=> irqPulse == '0
    ) else $error("auto-buffering interrupt away from half or full");

    a_irq_frame_end: assert property (
        busy && frameLast && !cur.mode.auto_buffering_mode
        && cur.mode.irq_enable_bit && cur.mode.irq_mode_bit
        |=> irqPulse[$past(busyCh)]
    ) else $error("no interrupt at frame end");

    a_xfer_half: assert property (
        busy |=> xfer.secondHalf == $past(dw && cur.phase)
    ) else $error("second half flag wrong on issued transfer");
endmodule : dma_count_index_irq
`default_nettype wire

// >>> rtl/dma_count_map.svh
// Notes on behaviour
// - Each channel keeps an 8-bit frame count; zero after reset means one frame.
// - Frames per block are count plus one; zero-means-one wins over 0FFh text.
// - Frame counter steps down only on the last read transfer of a frame.
// - At block end the frame counter reloads from global value if auto-reload set.
// - A 16-bit element counter steps down after every element read transfer but a frame's last, which restarts it.
// - Element count 0FFFFh gives 65536 elements in one frame.
// - With auto-reload, block end reloads the element counter from global value.
// - Doubleword mode makes two 16-bit transfers, both addresses move after each.
// - In doubleword mode the two transfers together form one element.
// - Source and destination select fields choose step register 0 or 1.
// - Every transfer but the frame's last adds the selected element step.
// - The frame's last transfer adds the selected frame step instead.
// - With the interrupt enable bit clear no interrupt is raised.
// - Auto-buffering: mode 0 full buffer only, mode 1 half and full.
// - Multi-frame: mode 0 at block end only, mode 1 each frame end too.
`ifndef DMA_COUNT_MAP_SVH
`define DMA_COUNT_MAP_SVH
`define DMA_CHANNELS 6
`define DMA_CH_W 3
`define DMA_WORD_W 16
`define DMA_FRAME_W 8
`define DMA_ELEM_RESET 16'h0000
`define DMA_FRAME_RESET 8'h00
`define DMA_ELEM_LAST 16'h0000
`define DMA_FRAME_LAST 8'h00
`define DMA_ELEM_ONE 16'h0001
`define DMA_FRAME_ONE 8'h01
`define DMA_ADDR_RESET 16'h0000
`endif

// >>> rtl/dma_count_pkg.sv
`include "dma_count_map.svh"
package dma_count_pkg;
    typedef logic [`DMA_CH_W-1:0] chan_t;
    typedef logic [`DMA_WORD_W-1:0] word_t;
    typedef logic [`DMA_FRAME_W-1:0] frame_t;

    // Per-channel mode bits, the channel_mode_control contents.
    typedef struct packed {
        logic auto_reload_enable;
        logic source_index_select;
        logic dest_index_select;
        logic doubleWord;
        logic auto_buffering_mode;
        logic irq_enable_bit;
        logic irq_mode_bit;
    } mode_t;

    // State kept for one channel in the channel memory.
    typedef struct packed {
        logic phase;
        word_t source_address_reg;
        word_t dest_address_reg;
        word_t element_count_reg;
        word_t elementInit;
        frame_t frame_count_reg;
        mode_t mode;
    } chan_state_t;

    // Software load of one channel; enable low stops the channel.
    typedef struct packed {
        chan_t channel;
        logic enable;
        word_t srcAddr;
        word_t dstAddr;
        word_t elemCount;
        frame_t frameCount;
        mode_t mode;
    } load_t;

    // Global reload and step registers shared by all channels.
    typedef struct packed {
        frame_t global_frame_reload;
        word_t global_count_reload;
        word_t element_step_0;
        word_t element_step_1;
        word_t frame_step_0;
        word_t frame_step_1;
    } globals_t;

    // One issued 16-bit transfer.
    typedef struct packed {
        chan_t channel;
        word_t srcAddr;
        word_t dstAddr;
        logic secondHalf;
        logic frameEnd;
        logic blockEnd;
    } xfer_t;
endpackage : dma_count_pkg

// >>> rtl/dma_chan_mem.sv
`timescale 1ns/1ps
`default_nettype none
module dma_chan_mem
    import dma_count_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic wrEn,
    input wire chan_t wrAddr,
    input wire chan_state_t wrData,
    input wire chan_t rdAddr,
    output chan_state_t rdData
);
    chan_state_t store [`DMA_CHANNELS];

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < `DMA_CHANNELS; i++) begin
                store[i] <= '0;
            end
        end else if (wrEn) begin
            store[wrAddr] <= wrData;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            rdData <= '0;
        end else begin
            rdData <= store[rdAddr];
        end
    end
endmodule : dma_chan_mem
`default_nettype wire

// >>> tb/dma_event_source.sv
`timescale 1ns/1ps
`default_nettype none
module dma_event_source
    import dma_count_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic go,
    input wire chan_t goChannel,
    input wire logic [1:0] delay,
    input wire logic stepReady,
    output logic stepValid,
    output chan_t stepChannel,
    output logic taken
);
    logic want;
    chan_t chanReg;
    logic [1:0] waitCount;
    assign stepValid = want && rst_n;
    assign stepChannel = rst_n ? chanReg : '0;
    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) taken <= 1'b0;
        else taken <= stepValid && stepReady;
    end
    // A request waits a few cycles to model a slow event source.
    always @(negedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            want <= 1'b0;
            chanReg <= '0;
            waitCount <= 2'h0;
        end else if (taken) begin
            want <= 1'b0;
            chanReg <= ~chanReg;
        end else if (go && !want) begin
            if (waitCount >= delay) begin
                want <= 1'b1;
                chanReg <= goChannel;
                waitCount <= 2'h0;
            end else begin
                waitCount <= waitCount + 2'h1;
            end
        end
    end
endmodule : dma_event_source
`default_nettype wire

// >>> tb/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import dma_count_pkg::*;
    logic core_clk = 1'b0;
    logic rst_n = 1'b0;
    globals_t globals = '0;
    logic loadValid = 1'b0;
    load_t loadData = '0;
    logic go = 1'b0;
    chan_t goChannel = '0;
    logic [1:0] delay = 2'h0;
    logic loadReady, stepReady, stepValid, taken, xferValid;
    chan_t stepChannel;
    xfer_t xfer;
    logic [`DMA_CHANNELS-1:0] channelActive, irqPulse;
    int badCount = 0;
    int comparisons = 0;
    logic [31:0] seed = 32'hA20F01A4;
    word_t mSrc, mDst, mElem, mInit;
    frame_t mFrame;
    logic mPhase, mActive;
    mode_t mMode;

    always #4 core_clk = ~core_clk;

    dma_count_index_irq u_dma_count_index_irq (.core_clk, .rst_n, .globals,
        .loadValid, .loadReady, .loadData, .stepValid, .stepReady,
        .stepChannel, .xferValid, .xfer, .channelActive, .irqPulse);
    dma_event_source u_dma_event_source (.core_clk, .rst_n, .go, .goChannel,
        .delay, .stepReady, .stepValid, .stepChannel, .taken);

    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd

    function automatic word_t pick(input logic sel, input logic last);
        if (last) return sel ? globals.frame_step_1 : globals.frame_step_0;
        return sel ? globals.element_step_1 : globals.element_step_0;
    endfunction : pick

    task automatic check(input logic [63:0] got, input logic [63:0] exp);
        comparisons++;
        if (got !== exp) begin
            badCount++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check

    task automatic completeRun();
        if (badCount == 0 && comparisons > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : completeRun

    task automatic modelStep(input chan_t ch, output xfer_t ex,
                             output logic [5:0] irq);
        logic last, moves, half;
        moves = !mMode.doubleWord || mPhase;
        last = moves && mElem == 16'h0000;
        half = moves && !last && mElem == (mInit >> 1);
        ex = '{ch, mSrc, mDst, mMode.doubleWord && mPhase, last,
               last && mFrame == 8'h00};
        irq = '0;
        irq[ch] = mMode.irq_enable_bit && (ex.blockEnd || mMode.irq_mode_bit
            && (mMode.auto_buffering_mode ? half : last));
        mSrc += pick(mMode.source_index_select, last);
        mDst += pick(mMode.dest_index_select, last);
        if (mMode.doubleWord) mPhase = !mPhase;
        if (moves) begin
            if (!last) begin
                mElem--;
            end else if (mFrame != 8'h00) begin
                mFrame--;
                mElem = mInit;
            end else if (mMode.auto_reload_enable) begin
                mFrame = globals.global_frame_reload;
                mElem = globals.global_count_reload;
                mInit = globals.global_count_reload;
            end else begin
                mActive = 1'b0;
            end
        end
    endtask : modelStep

    task automatic doLoad(input load_t ld);
        @(negedge core_clk);
        loadValid <= 1'b1;
        loadData <= ld;
        @(negedge core_clk);
        loadValid <= 1'b0;
        check(64'(channelActive[ld.channel]), 64'(ld.enable));
        {mSrc, mDst, mElem, mInit} = {ld.srcAddr, ld.dstAddr, ld.elemCount,
                                      ld.elemCount};
        {mFrame, mMode, mActive, mPhase} = {ld.frameCount, ld.mode,
                                            ld.enable, 1'b0};
    endtask : doLoad

    task automatic doStep(input chan_t ch);
        xfer_t ex;
        logic [5:0] irq;
        logic live;
        int n;
        n = 0;
        @(negedge core_clk);
        globals <= $bits(globals_t)'({rnd(), rnd(), rnd()});
        go <= 1'b1;
        goChannel <= ch;
        delay <= 2'(rnd());
        while (!taken && n < 20) begin
            @(posedge core_clk);
            #1;
            n++;
        end
        check(64'(taken), 64'h1);
        live = mActive && ch < 3'h6;
        if (live) modelStep(ch, ex, irq);
        @(negedge core_clk);
        go <= 1'b0;
        check(64'(xferValid), 64'h0);
        check(64'({loadReady, stepReady}), 64'({2{!live}}));
        @(posedge core_clk);
        @(negedge core_clk);
        check(64'(xferValid), 64'(live));
        if (live) begin
            check(64'(xfer), 64'(ex));
            check(64'(irqPulse), 64'(irq));
            check(64'(channelActive[ch]), 64'(mActive));
        end
    endtask : doStep

    task automatic runBlock(input chan_t ch, input word_t e, input frame_t f,
                            input mode_t md);
        int k;
        doLoad('{ch, 1'b1, 16'(rnd()), 16'(rnd()), e, f, md});
        k = (int'(e) + 1) * (int'(f) + 1) * (md.doubleWord ? 2 : 1) + 3;
        repeat (k) doStep(ch);
        doStep(3'h6);
    endtask : runBlock

    initial begin
        repeat (20) @(posedge core_clk);
        @(negedge core_clk);
        rst_n <= 1'b1;
        runBlock(3'h2, 16'h0000, 8'hFF, mode_t'(7'h00));
        runBlock(3'h5, 16'h0003, 8'h01, mode_t'(7'h0F));
        runBlock(3'h0, 16'h0002, 8'h02, mode_t'(7'h73));
        repeat (40) runBlock(3'(rnd() % 6), 16'(rnd() % 4), 8'(rnd() % 3),
                             mode_t'(7'(rnd())));
        completeRun();
    end

    initial begin
        #(8 * 30000);
        badCount++;
        completeRun();
    end
endmodule : testbench
`default_nettype wire
